// File: src/ulf_ctrl.sv
// Per-channel FIFO, line format and modem output control with its register port.
`timescale 1ns/1ps
// How it works
// R1: Status bits 7:6 both read as the FIFO enable state.
// R2: FIFO control bit 0 enables FIFOs; other bits ignored unless it is set.
// R3: Bit 1 with enable gives a one-cycle receive FIFO clear, then self-clears.
// R4: Bit 2 with enable gives a one-cycle transmit FIFO clear, then self-clears.
// R5: Bit 3 selects DMA mode for the ready pins; zero after reset.
// R6: Bits 7:6 pick trigger 1, 4, 8 or 14; hit when count reaches it.
// R7: Line bits 1:0 set character length 5 to 8 for both directions.
// R8: Line bit 2 gives one, one and a half or two stop bits.
// R9: Line bit 3 adds a parity bit on send and checks it on receive.
// R10: Line bit 4 chooses odd (zero) or even (one) parity.
// R11: Line bit 5 forces parity high with bit 4 low, low otherwise.
// R12: Line bit 6 holds the serial output low until software clears it.
// R13: Line bit 7 steers low addresses to the divisor latch bytes.
// R14: Modem bit 0 drives the terminal-ready pin inverted.
// R15: Modem bit 1 drives the request-to-send pin inverted.
// R16: Modem bit 2 feeds the ring indicator status in loopback.
// R17: Modem bit 3 drives the second user output inverted in loopback.
// R18: Interrupt pin floats when the alternate bus mode pin, select pin and modem bit 3 are all zero.
// R19: The other party keeps the select pin low in the alternate bus mode.
// R20: The two divisor bytes join high over low into one 16-bit value.
// R21: In loopback carrier-detect status reads modem bit 3.
// R22: Reserved bits ignore writes and read as zero.
module ulf_ctrl #(
  parameter int unsigned CNT_W = 5
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [ulf_pkg::ULF_ADDR_W-1:0] addr_i,
  input wire logic [ulf_pkg::ULF_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [3:0] int_id_i,
  input wire logic irq_pending_i,
  input wire logic [CNT_W-1:0] rx_count_i,
  input wire logic tx_serial_raw_i,
  input wire logic [7:0] tx_char_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_parity_i,
  input wire logic ring_indicator_in_n_i,
  input wire logic cd_in_n_i,
  input wire logic irq_output_select_i,
  input wire logic alt_bus_mode_i,
  output logic [ulf_pkg::ULF_DATA_W-1:0] rdata_o,
  output logic fifo_en_o,
  output logic rx_fifo_clear_o,
  output logic tx_fifo_clear_o,
  output logic dma_mode_o,
  output logic [CNT_W-1:0] rx_trig_level_o,
  output logic rx_trigger_hit_o,
  output ulf_pkg::ulf_fmt_t line_fmt_o,
  output logic [15:0] divisor_o,
  output logic tx_serial_o,
  output logic tx_parity_bit_o,
  output logic rx_parity_err_o,
  output logic dtr_n_o,
  output logic rts_n_o,
  output logic user_out1_n_o,
  output logic user_out2_n_o,
  output logic loopback_o,
  output logic ri_status_o,
  output logic cd_status_o,
  output logic irq_o,
  output logic irq_oe_o
);
  import ulf_pkg::*;

  function automatic logic [4:0] ulf_trig_level(input logic [1:0] sel);
    logic [4:0] lvl;
    case (sel)
      2'h0: lvl = ULF_TRIG_1;
      2'h1: lvl = ULF_TRIG_4;
      2'h2: lvl = ULF_TRIG_8;
      default: lvl = ULF_TRIG_14;
    endcase
    return lvl;
  endfunction

  function automatic logic [3:0] ulf_word_len(input logic [1:0] sel);
    return ULF_LEN_BASE + {2'b00, sel};
  endfunction

  // Bits above the programmed length are masked, so the sender may leave junk there.
  function automatic logic ulf_parity_bit(input logic [7:0] data, input ulf_fmt_t f);
    logic [7:0] m;
    m = data & (8'hff >> (4'h8 - f.data_bits));
    if (f.parity_forced)
    begin
      return !f.parity_even;
    end
    return f.parity_even ? (^m) : !(^m);
  endfunction

  logic fifo_en_q;
  logic dma_q;
  logic [1:0] trig_sel_q;
  logic rx_clr_q;
  logic tx_clr_q;
  logic [7:0] lcr_q;
  logic [MCR_W-1:0] mcr_q;
  logic dlab;
  logic fcr_wr;
  logic fcr_arm;
  logic div_wr;
  logic [7:0] rd_mux;
  ulf_fmt_t fmt_d;

  assign dlab = lcr_q[LCR_DLAB];
  assign fcr_wr = wr_i && (addr_i == ULF_ADDR_ISR_FCR);
  assign fcr_arm = fcr_wr && wdata_i[FCR_ENABLE]; // R2
  assign div_wr = wr_i && dlab && (addr_i == ULF_ADDR_DIV_LO || addr_i == ULF_ADDR_DIV_HI); // R13

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fifo_en_q <= 1'b0;
      dma_q <= 1'b0;
      trig_sel_q <= ULF_TRIG_RST;
    end
    else if (ce_i && fcr_wr)
    begin
      fifo_en_q <= wdata_i[FCR_ENABLE]; // R2
      if (fcr_arm)
      begin
        dma_q <= wdata_i[FCR_DMA]; // R5
        trig_sel_q <= wdata_i[FCR_TRIG_LO +: 2]; // R6
      end
    end
  end

  // The clear strobes are pulses, so the bits never read back as set.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_clr_q <= 1'b0;
      tx_clr_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_clr_q <= fcr_arm && wdata_i[FCR_RX_CLEAR]; // R3
      tx_clr_q <= fcr_arm && wdata_i[FCR_TX_CLEAR]; // R4
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lcr_q <= ULF_LCR_RST;
    end
    else if (ce_i && wr_i && addr_i == ULF_ADDR_LCR)
    begin
      lcr_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mcr_q <= ULF_MCR_RST;
    end
    else if (ce_i && wr_i && addr_i == ULF_ADDR_MCR)
    begin
      mcr_q <= wdata_i[MCR_W-1:0]; // R22
    end
  end

  ulf_divisor_latch #(
    .BYTE_W(8)
  ) u_div (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .wr_i(div_wr),
    .sel_hi_i(addr_i[0]),
    .wdata_i(wdata_i),
    .divisor_o(divisor_o)
  );

  always_comb
  begin
    rd_mux = 8'h00;
    case (addr_i)
      ULF_ADDR_DIV_LO: rd_mux = dlab ? divisor_o[7:0] : 8'h00; // R13
      ULF_ADDR_DIV_HI: rd_mux = dlab ? divisor_o[15:8] : 8'h00; // R20
      ULF_ADDR_ISR_FCR: rd_mux = {fifo_en_q, fifo_en_q, 2'b00, int_id_i}; // R1 R22
      ULF_ADDR_LCR: rd_mux = lcr_q;
      ULF_ADDR_MCR: rd_mux = {3'b000, mcr_q}; // R22
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (ce_i && rd_i)
    begin
      rdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fifo_en_o <= 1'b0;
      rx_fifo_clear_o <= 1'b0;
      tx_fifo_clear_o <= 1'b0;
      dma_mode_o <= 1'b0;
      rx_trig_level_o <= '0;
      rx_trigger_hit_o <= 1'b0;
    end
    else if (ce_i)
    begin
      fifo_en_o <= fifo_en_q;
      rx_fifo_clear_o <= rx_clr_q; // R3
      tx_fifo_clear_o <= tx_clr_q; // R4
      dma_mode_o <= dma_q; // R5
      rx_trig_level_o <= CNT_W'(ulf_trig_level(trig_sel_q)); // R6
      rx_trigger_hit_o <= fifo_en_q && (rx_count_i >= CNT_W'(ulf_trig_level(trig_sel_q))); // R6
    end
  end

  always_comb
  begin
    fmt_d.data_bits = ulf_word_len(lcr_q[LCR_LEN_LO +: 2]); // R7
    if (!lcr_q[LCR_STOP])
    begin
      fmt_d.stop_halves = ULF_STOP_ONE; // R8
    end
    else if (lcr_q[LCR_LEN_LO +: 2] == 2'h0)
    begin
      fmt_d.stop_halves = ULF_STOP_ONE_HALF; // R8
    end
    else
    begin
      fmt_d.stop_halves = ULF_STOP_TWO; // R8
    end
    fmt_d.parity_en = lcr_q[LCR_PAR_EN]; // R9
    fmt_d.parity_even = lcr_q[LCR_PAR_EVEN]; // R10
    fmt_d.parity_forced = lcr_q[LCR_PAR_FORCE]; // R11
    fmt_d.brk = lcr_q[LCR_BREAK];
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      line_fmt_o <= '0;
      tx_serial_o <= 1'b1;
      tx_parity_bit_o <= 1'b0;
      rx_parity_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      line_fmt_o <= fmt_d;
      tx_serial_o <= lcr_q[LCR_BREAK] ? 1'b0 : tx_serial_raw_i; // R12
      tx_parity_bit_o <= fmt_d.parity_en && ulf_parity_bit(tx_char_i, fmt_d); // R9 R10 R11
      rx_parity_err_o <= fmt_d.parity_en && (rx_parity_i != ulf_parity_bit(rx_char_i, fmt_d)); // R9
    end
  end

  // Outside loopback the two user outputs have no pin, so they idle high.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dtr_n_o <= 1'b1;
      rts_n_o <= 1'b1;
      user_out1_n_o <= 1'b1;
      user_out2_n_o <= 1'b1;
      loopback_o <= 1'b0;
      ri_status_o <= 1'b0;
      cd_status_o <= 1'b0;
    end
    else if (ce_i)
    begin
      dtr_n_o <= !mcr_q[MCR_DTR]; // R14
      rts_n_o <= !mcr_q[MCR_RTS]; // R15
      user_out1_n_o <= mcr_q[MCR_LOOP] ? !mcr_q[MCR_OUT1] : 1'b1;
      user_out2_n_o <= mcr_q[MCR_LOOP] ? !mcr_q[MCR_OUT2] : 1'b1; // R17
      loopback_o <= mcr_q[MCR_LOOP];
      ri_status_o <= mcr_q[MCR_LOOP] ? mcr_q[MCR_OUT1] : !ring_indicator_in_n_i; // R16
      cd_status_o <= mcr_q[MCR_LOOP] ? mcr_q[MCR_OUT2] : !cd_in_n_i; // R21
    end
  end

  // In the alternate bus mode the pin is always driven, whatever the level of the select pin.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_o <= 1'b0;
      irq_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_o <= irq_pending_i;
      irq_oe_o <= alt_bus_mode_i || irq_output_select_i || mcr_q[MCR_OUT2]; // R18 R19
    end
  end

  sequence s_rx_clear_req;
    ce_i && fcr_wr && wdata_i[FCR_ENABLE] && wdata_i[FCR_RX_CLEAR];
  endsequence

  sequence s_tx_clear_req;
    ce_i && fcr_wr && wdata_i[FCR_ENABLE] && wdata_i[FCR_TX_CLEAR];
  endsequence

  sequence s_quiet;
    ce_i && !fcr_wr;
  endsequence

  chk_isr_fifo_bits: assert property ( // R1
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && rd_i && addr_i == ULF_ADDR_ISR_FCR) |=>
      (rdata_o[7:6] == {2{$past(fifo_en_q)}}) && (rdata_o[5:4] == 2'b00))
    else $error("status read shows wrong FIFO enable bits");

  chk_fcr_gate_off: assert property ( // R2
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && fcr_wr && !wdata_i[FCR_ENABLE]) |=>
      $stable(dma_q) && $stable(trig_sel_q) && !fifo_en_q ##1 (!rx_fifo_clear_o && !tx_fifo_clear_o))
    else $error("FIFO control bits took effect without enable");

  chk_rx_clear_pulse: assert property ( // R3
    @(posedge clk_i) disable iff (!arst_n_i)
    s_rx_clear_req ##1 s_quiet |-> ##1 (rx_fifo_clear_o && !rx_clr_q))
    else $error("receive FIFO clear is not a single pulse");

  chk_tx_clear_pulse: assert property ( // R4
    @(posedge clk_i) disable iff (!arst_n_i)
    s_tx_clear_req ##1 s_quiet |-> ##1 (tx_fifo_clear_o && !tx_clr_q))
    else $error("transmit FIFO clear is not a single pulse");

  chk_dma_select: assert property ( // R5
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && fcr_arm) ##1 ce_i |=> dma_mode_o == $past(wdata_i[FCR_DMA], 2))
    else $error("DMA mode output does not follow the write");

  chk_trigger_hit: assert property ( // R6
    @(posedge clk_i) disable iff (!arst_n_i)
    ce_i |=> rx_trigger_hit_o ==
      ($past(fifo_en_q) && ($past(rx_count_i) >= CNT_W'(ulf_trig_level($past(trig_sel_q))))))
    else $error("receive trigger hit wrong");

  chk_word_len: assert property ( // R7
    @(posedge clk_i) disable iff (!arst_n_i)
    ce_i |=> line_fmt_o.data_bits == ulf_word_len($past(lcr_q[1:0])))
    else $error("character length wrong");

  chk_stop_half: assert property ( // R8
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && lcr_q[LCR_STOP] && lcr_q[1:0] == 2'h0) |=> line_fmt_o.stop_halves == 3'h3)
    else $error("one and a half stop bits not selected");

  chk_break_hold: assert property ( // R12
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && lcr_q[LCR_BREAK]) |=> !tx_serial_o)
    else $error("break does not hold the line low");

  chk_modem_pins: assert property ( // R14 R15
    @(posedge clk_i) disable iff (!arst_n_i)
    ce_i |=> (dtr_n_o != $past(mcr_q[MCR_DTR])) && (rts_n_o != $past(mcr_q[MCR_RTS])))
    else $error("modem output pins not inverted from control bits");

  chk_irq_float: assert property ( // R18
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && !alt_bus_mode_i && !irq_output_select_i && !mcr_q[MCR_OUT2]) |=> !irq_oe_o)
    else $error("interrupt pin driven while it should float");

  chk_loop_cd: assert property ( // R21
    @(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && mcr_q[MCR_LOOP]) |=> (cd_status_o == $past(mcr_q[MCR_OUT2])) &&
      (ri_status_o == $past(mcr_q[MCR_OUT1])))
    else $error("loopback status does not follow the control bits");

endmodule

// File: src/ulf_divisor_latch.sv
// Two-byte baud divisor latch that presents the joined 16-bit divisor.
`timescale 1ns/1ps
module ulf_divisor_latch #(
  parameter int unsigned BYTE_W = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic sel_hi_i,
  input wire logic [BYTE_W-1:0] wdata_i,
  output logic [2*BYTE_W-1:0] divisor_o
);
  import ulf_pkg::*;

  logic [BYTE_W-1:0] lo_q;
  logic [BYTE_W-1:0] hi_q;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lo_q <= BYTE_W'(ULF_DIV_RST);
      hi_q <= BYTE_W'(ULF_DIV_RST);
    end
    else if (ce_i && wr_i)
    begin
      if (sel_hi_i)
      begin
        hi_q <= wdata_i;
      end
      else
      begin
        lo_q <= wdata_i;
      end
    end
  end

  // The joined value is re-registered so the divider never sees a half-written pair mid-cycle.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      divisor_o <= '0;
    end
    else if (ce_i)
    begin
      divisor_o <= {hi_q, lo_q}; // R20
    end
  end

endmodule

// File: src/ulf_pkg.sv
// Constants, field layouts and carrier types for the line, FIFO and modem control block.
package ulf_pkg;

  localparam int unsigned ULF_ADDR_W = 3;
  localparam int unsigned ULF_DATA_W = 8;

  localparam logic [2:0] ULF_ADDR_DIV_LO = 3'h0;
  localparam logic [2:0] ULF_ADDR_DIV_HI = 3'h1;
  localparam logic [2:0] ULF_ADDR_ISR_FCR = 3'h2;
  localparam logic [2:0] ULF_ADDR_LCR = 3'h3;
  localparam logic [2:0] ULF_ADDR_MCR = 3'h4;

  localparam int unsigned FCR_ENABLE = 0;
  localparam int unsigned FCR_RX_CLEAR = 1;
  localparam int unsigned FCR_TX_CLEAR = 2;
  localparam int unsigned FCR_DMA = 3;
  localparam int unsigned FCR_TRIG_LO = 6;

  localparam int unsigned LCR_LEN_LO = 0;
  localparam int unsigned LCR_STOP = 2;
  localparam int unsigned LCR_PAR_EN = 3;
  localparam int unsigned LCR_PAR_EVEN = 4;
  localparam int unsigned LCR_PAR_FORCE = 5;
  localparam int unsigned LCR_BREAK = 6;
  localparam int unsigned LCR_DLAB = 7;

  localparam int unsigned MCR_DTR = 0;
  localparam int unsigned MCR_RTS = 1;
  localparam int unsigned MCR_OUT1 = 2;
  localparam int unsigned MCR_OUT2 = 3;
  localparam int unsigned MCR_LOOP = 4;
  localparam int unsigned MCR_W = 5;

  localparam logic [7:0] ULF_LCR_RST = 8'h00;
  localparam logic [4:0] ULF_MCR_RST = 5'h00;
  localparam logic [1:0] ULF_TRIG_RST = 2'h0;
  localparam logic [7:0] ULF_DIV_RST = 8'h00;

  localparam logic [3:0] ULF_LEN_BASE = 4'h5;
  localparam logic [4:0] ULF_TRIG_1 = 5'h01;
  localparam logic [4:0] ULF_TRIG_4 = 5'h04;
  localparam logic [4:0] ULF_TRIG_8 = 5'h08;
  localparam logic [4:0] ULF_TRIG_14 = 5'h0e;
  localparam logic [2:0] ULF_STOP_ONE = 3'h2;
  localparam logic [2:0] ULF_STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] ULF_STOP_TWO = 3'h4;

  // Stop length is carried in half bit times so that 1.5 stays exact.
  typedef struct packed {
    logic [3:0] data_bits;
    logic [2:0] stop_halves;
    logic parity_en;
    logic parity_even;
    logic parity_forced;
    logic brk;
  } ulf_fmt_t;

endpackage

// File: tb/ulf_ctrl_tb.sv
// Self-checking bench for the line, FIFO and modem control block.
`timescale 1ns/1ps
module ulf_ctrl_tb;
  import ulf_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce, wr, rd, alt, sel;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] int_id = 4'h5;
  logic irq_pend = 1'b0;
  logic [4:0] rx_count = 5'h00;
  logic tx_raw = 1'b1;
  logic [7:0] tx_char = 8'h0b;
  logic [7:0] rx_char = 8'h0b;
  logic rx_par = 1'b1;
  logic ri_n = 1'b1;
  logic cd_n = 1'b1;
  logic fifo_en, rx_clr, tx_clr, dma, hit, tx_ser, tx_pb, rx_perr;
  logic dtr_n, rts_n, uo1_n, uo2_n, loopb, ri_st, cd_st, irq, irq_oe;
  logic [4:0] trig;
  ulf_fmt_t fmt;
  logic [15:0] div;
  int err_count = 0;
  int checked = 0;

  always #20 clk_i = ~clk_i;

  ulf_host_model u_ulf_host_model (
    .clk_i(clk_i), .rdata_i(rdata), .ce_o(ce), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .alt_bus_mode_o(alt), .irq_output_select_o(sel)
  );

  ulf_ctrl u_ulf_ctrl (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .int_id_i(int_id), .irq_pending_i(irq_pend),
    .rx_count_i(rx_count), .tx_serial_raw_i(tx_raw), .tx_char_i(tx_char),
    .rx_char_i(rx_char), .rx_parity_i(rx_par), .ring_indicator_in_n_i(ri_n),
    .cd_in_n_i(cd_n), .irq_output_select_i(sel), .alt_bus_mode_i(alt),
    .rdata_o(rdata), .fifo_en_o(fifo_en), .rx_fifo_clear_o(rx_clr),
    .tx_fifo_clear_o(tx_clr), .dma_mode_o(dma), .rx_trig_level_o(trig),
    .rx_trigger_hit_o(hit), .line_fmt_o(fmt), .divisor_o(div), .tx_serial_o(tx_ser),
    .tx_parity_bit_o(tx_pb), .rx_parity_err_o(rx_perr), .dtr_n_o(dtr_n),
    .rts_n_o(rts_n), .user_out1_n_o(uo1_n), .user_out2_n_o(uo2_n),
    .loopback_o(loopb), .ri_status_o(ri_st), .cd_status_o(cd_st), .irq_o(irq),
    .irq_oe_o(irq_oe)
  );

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic w(input logic [2:0] a, input logic [7:0] d);
    u_ulf_host_model.write_reg(a, d);
  endtask

  task automatic r(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_ulf_host_model.read_reg(a, d);
    chk(d, exp);
  endtask

  task automatic t_reset();
    settle(1);
    chk({dtr_n, rts_n, uo1_n, uo2_n, irq_oe, tx_ser}, 16'h003d);
    r(ULF_ADDR_ISR_FCR, 8'h05);
    r(ULF_ADDR_LCR, 8'h00);
    r(ULF_ADDR_MCR, 8'h00);
    r(3'h5, 8'h00);
  endtask

  task automatic t_fifo();
    logic [4:0] lvl;
    w(ULF_ADDR_ISR_FCR, 8'hce);
    settle(1);
    chk({fifo_en, rx_clr, tx_clr, dma, trig}, {4'h0, ULF_TRIG_1});
    w(ULF_ADDR_ISR_FCR, 8'h3f);
    settle(1);
    chk({fifo_en, rx_clr, tx_clr, dma}, 4'hf);
    settle(1);
    chk({rx_clr, tx_clr}, 2'h0);
    r(ULF_ADDR_ISR_FCR, 8'hc5);
    for (int k = 0; k < 4; k++)
    begin
      w(ULF_ADDR_ISR_FCR, {2'(k), 6'h01});
      lvl = (k == 0) ? ULF_TRIG_1 : (k == 1) ? ULF_TRIG_4 : (k == 2) ? ULF_TRIG_8 : ULF_TRIG_14;
      rx_count = lvl - 5'h01;
      settle(2);
      chk({trig, hit}, {lvl, 1'b0});
      rx_count = lvl;
      settle(2);
      chk(hit, 1'b1);
    end
    chk(dma, 1'b0);
    w(ULF_ADDR_ISR_FCR, 8'h00);
    settle(2);
    chk({fifo_en, hit}, 2'h0);
    r(ULF_ADDR_ISR_FCR, 8'h05);
  endtask

  // Received parity bit is held at one, so the error flag flips with the mode.
  task automatic par(input logic [7:0] v, input logic t, input logic e);
    w(ULF_ADDR_LCR, v);
    settle(2);
    chk({fmt.parity_en, fmt.parity_even, fmt.parity_forced, tx_pb, rx_perr},
        {v[3], v[4], v[5], t, e});
  endtask

  task automatic t_line();
    for (int k = 0; k < 4; k++)
    begin
      w(ULF_ADDR_LCR, {6'h01, 2'(k)});
      settle(2);
      chk({fmt.data_bits, fmt.stop_halves},
          {ULF_LEN_BASE + 4'(k), (k == 0) ? ULF_STOP_ONE_HALF : ULF_STOP_TWO});
    end
    w(ULF_ADDR_LCR, 8'h03);
    settle(2);
    chk(fmt.stop_halves, ULF_STOP_ONE);
    par(8'h03, 1'b0, 1'b0);
    par(8'h0b, 1'b0, 1'b1);
    par(8'h1b, 1'b1, 1'b0);
    par(8'h2b, 1'b1, 1'b0);
    par(8'h3b, 1'b0, 1'b1);
    r(ULF_ADDR_LCR, 8'h3b);
  endtask

  task automatic t_break();
    w(ULF_ADDR_LCR, 8'h43);
    settle(2);
    chk({fmt.brk, tx_ser}, 2'b10);
    tx_raw = 1'b0;
    settle(2);
    tx_raw = 1'b1;
    settle(2);
    chk(tx_ser, 1'b0);
    w(ULF_ADDR_LCR, 8'h03);
    settle(2);
    chk(tx_ser, 1'b1);
    tx_raw = 1'b0;
    settle(2);
    chk(tx_ser, 1'b0);
    tx_raw = 1'b1;
  endtask

  task automatic t_divisor();
    w(ULF_ADDR_LCR, 8'h83);
    w(ULF_ADDR_DIV_LO, 8'h34);
    w(ULF_ADDR_DIV_HI, 8'h12);
    settle(2);
    chk(div, 16'h1234);
    r(ULF_ADDR_DIV_LO, 8'h34);
    r(ULF_ADDR_DIV_HI, 8'h12);
    w(ULF_ADDR_LCR, 8'h03);
    r(ULF_ADDR_DIV_LO, 8'h00);
    r(ULF_ADDR_DIV_HI, 8'h00);
    w(ULF_ADDR_DIV_LO, 8'h55);
    settle(2);
    chk(div, 16'h1234);
  endtask

  task automatic t_modem();
    w(ULF_ADDR_MCR, 8'h01);
    settle(2);
    chk({dtr_n, rts_n, uo1_n, uo2_n, irq_oe}, 5'b01110);
    w(ULF_ADDR_MCR, 8'h02);
    settle(2);
    chk({dtr_n, rts_n, uo1_n, uo2_n, irq_oe}, 5'b10110);
    w(ULF_ADDR_MCR, 8'h08);
    settle(2);
    chk({dtr_n, rts_n, uo1_n, uo2_n, irq_oe}, 5'b11111);
    w(ULF_ADDR_MCR, 8'h00);
    u_ulf_host_model.set_pins(1'b0, 1'b1);
    settle(2);
    chk(irq_oe, 1'b1);
    u_ulf_host_model.set_pins(1'b1, 1'b1);
    settle(2);
    chk({sel, irq_oe}, 2'b01);
    u_ulf_host_model.set_pins(1'b0, 1'b0);
    ri_n = 1'b0;
    cd_n = 1'b0;
    settle(2);
    chk({irq_oe, loopb, ri_st, cd_st}, 4'b0011);
    ri_n = 1'b1;
    cd_n = 1'b1;
    w(ULF_ADDR_MCR, 8'hff);
    settle(2);
    chk({loopb, ri_st, cd_st, uo1_n, uo2_n}, 5'b11100);
    r(ULF_ADDR_MCR, 8'h1f);
    ri_n = 1'b0;
    cd_n = 1'b0;
    w(ULF_ADDR_MCR, 8'h10);
    settle(2);
    chk({loopb, ri_st, cd_st, uo1_n, uo2_n}, 5'b10011);
    irq_pend = 1'b1;
    settle(2);
    chk(irq, 1'b1);
    irq_pend = 1'b0;
  endtask

  // With the enable low a write must not land, so break stays off and the old value reads back.
  task automatic t_freeze();
    u_ulf_host_model.set_ce(1'b0);
    w(ULF_ADDR_LCR, 8'h40);
    settle(2);
    chk(tx_ser, 1'b1);
    u_ulf_host_model.set_ce(1'b1);
    r(ULF_ADDR_LCR, 8'h03);
  endtask

  // The whole run is under two hundred cycles; the limit leaves a wide margin.
  initial
  begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    t_reset();
    t_fifo();
    t_line();
    t_break();
    t_divisor();
    t_modem();
    t_freeze();
    tally_and_finish();
  end
endmodule

// File: tb/ulf_host_model.sv
// Host processor model driving the register port and the bus-mode pins.
`timescale 1ns/1ps
module ulf_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic ce_o,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic alt_bus_mode_o,
  output logic irq_output_select_o
);
  initial
  begin
    ce_o = 1'b1;
    addr_o = 3'h7;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    alt_bus_mode_o = 1'b0;
    irq_output_select_o = 1'b0;
  end

  // Strobes are held across one sampling edge and dropped just after it.
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask

  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask

  // The enable is changed at once, without waiting for an edge like the other request signals.
  task automatic set_ce(input logic v);
    ce_o = v;
  endtask

  // A real host may ask for select high in the alternate mode; it is kept low.
  task automatic set_pins(input logic alt, input logic sel);
    alt_bus_mode_o = alt;
    irq_output_select_o = sel & ~alt;
  endtask
endmodule
